// ---- hdl/tfba_allocator.v ----
// Contract
// - 16 kHz: glottal shape in one of five
// - Subframes before glottal shape: algebraic only
// - Subframes after glottal shape: adaptive plus algebraic
// - 16 kHz prefix codes 00 01 10 110 111
// - Up to 32 kbps: joint vector gain quantization
// - 64 kbps: separate scalar gain quantizers
// - Zero first stage: algebraic gain only
// - Optimal gain is correlation over energy plus epsilon
// - Index is largest below midpoint threshold
// - Three-bit index; gain is entry times prediction
// - Two impulses first: pitch 34..N, 6 bits
// - Later pitches delta coded, 5 or 6 bits
// - Second subframe impulse: 7-bit pitch in subframe two
// - Then third, fourth delta coded in 6 bits
// - Third subframe impulse: subframe two zero excitation
// - Third subframe pitch 7 bits, wide range
// - Fourth subframe delta coded 5 or 6 bits
// - Subframe two carries 3-bit algebraic gain only
// - Fourth-subframe impulse: pitch only in fourth
// - Fourth pitch sent even if impulse later
// - That case: subframes two, three 3-bit gains
// - 12.8 kHz: glottal shape in one of four
// - 12.8 kHz prefix codes for configurations one..seven
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "tfba_regs.vh"
module tfba_allocator (
    input wire clock,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Frame fields towards the packer, all held between done pulses
    output reg frame_done_reg,
    output reg [3:0] prefix_code_reg,
    output reg [2:0] prefix_len_reg,
    output reg [14:0] sub_mode_reg,
    output reg [14:0] pitch_bits_reg,
    output reg [9:0] gain_bits_reg,
    output reg [2:0] gain_index_reg,
    output reg [31:0] gain_quant_reg
);
    // Mode codes per subframe: 0 algebraic, 1 glottal+alg, 2 adaptive+alg
    // Codes above 2 are never produced
    localparam M_ALG = 3'h0;
    localparam M_GS = 3'h1;
    localparam M_ADA = 3'h2;
    // Gain coding codes: 0 none, 1 3-bit alg only, 2 vector, 3 scalar pair
    // Zero means the subframe carries no gain field at all
    localparam G_ALG3 = 2'h1;
    localparam G_VQ = 2'h2;
    localparam G_SQ = 2'h3;
    // Sequencer states; the search walks the table from the top down
    localparam ST_IDLE = 2'h0;
    localparam ST_CALC = 2'h1;
    localparam ST_SRCH = 2'h2;

    // Software-written frame inputs, held while a frame is in flight
    reg [2:0] ctrl_reg;
    reg [23:0] frame_reg;

    // Gain datapath inputs: correlation, energy, predicted gain
    reg [31:0] corr_reg;
    reg [31:0] energy_reg;
    reg [31:0] pred_reg;

    // Eight-entry correction table, unsigned 0.16
    reg [15:0] table_reg [0:7];

    // Sequencer and divider state
    reg [1:0] state_reg;
    reg [2:0] idx_reg;
    reg [31:0] gopt_reg;
    reg [31:0] div_cnt_reg;
    reg [31:0] rem_reg;
    reg [2:0] pitch_cfg_reg;
    reg [7:0] pmin_reg;
    reg [7:0] pmax_reg;
    reg busy_reg;

    // Frame field views; the rate bits pick the configuration set
    // and the delta pitch width for the whole frame
    // Both are sampled from the control word written with start
    wire rate16 = ctrl_reg[`TFBA_CTRL_RATE16];
    wire rate64 = ctrl_reg[`TFBA_CTRL_RATE64];
    wire [7:0] sub_len = frame_reg[7:0];
    wire [7:0] imp_pos = frame_reg[15:8];
    wire [2:0] gs_sub = frame_reg[18:16];
    wire [2:0] nsub = rate16 ? `TFBA_NSUB16 : `TFBA_NSUB12;
    wire [1:0] dbits = rate64 ? 2'h2 : 2'h1;

    // Prefix code of the selected placement, right-aligned
    // Codes are prefix-free, so the packer needs only the length
    // to place them; unused upper bits stay zero
    reg [3:0] code_next;
    reg [2:0] clen_next;
    always @* begin
        code_next = 4'h0;
        clen_next = 3'h2;
        if (rate16) begin
            // Wide rate: five placements, two or three bits
            case (gs_sub)
                3'h0: begin code_next = 4'h0; clen_next = 3'h2; end
                3'h1: begin code_next = 4'h1; clen_next = 3'h2; end
                3'h2: begin code_next = 4'h2; clen_next = 3'h2; end
                3'h3: begin code_next = 4'h6; clen_next = 3'h3; end
                default: begin code_next = 4'h7; clen_next = 3'h3; end
            endcase
        end else begin
            // Narrow rate: seven configurations, one to four bits
            case (frame_reg[21:19])
                3'h0: begin code_next = 4'h1; clen_next = 3'h1; end
                3'h1: begin code_next = 4'h5; clen_next = 3'h4; end
                3'h2: begin code_next = 4'h4; clen_next = 3'h4; end
                3'h3: begin code_next = 4'h3; clen_next = 3'h3; end
                3'h4: begin code_next = 4'h1; clen_next = 3'h3; end
                3'h5: begin code_next = 4'h1; clen_next = 3'h4; end
                default: begin code_next = 4'h0; clen_next = 3'h4; end
            endcase
        end
    end

    // Configuration at 12.8 kHz: frame_reg[21:19] 0..3 -> four first-subframe cases
    // Codes 4..6 only move the glottal slot; their pitch fields get no special
    // case, though the range block gives them the code 3 range, keeping the decode small
    wire [2:0] cfg12 = frame_reg[21:19];
    wire [2:0] gs_eff = rate16 ? gs_sub : ((cfg12 < 3'h4) ? 3'h0 : cfg12 - 3'h3);

    // Per-subframe codebook, pitch width and gain coding
    // Generic placement first, then the first-subframe cases of the
    // narrow rate override the fields they own; subframes beyond the
    // frame length stay zero
    reg [14:0] mode_next;
    reg [14:0] pitch_next;
    reg [9:0] gain_next;
    integer i;
    always @* begin
        mode_next = 15'h0000;
        pitch_next = 15'h0000;
        gain_next = 10'h000;
        for (i = 0; i < 5; i = i + 1) begin
            // Before, at and after the glottal slot
            if (i[2:0] < nsub) begin
                if (i[2:0] < gs_eff) begin
                    mode_next[i*3 +: 3] = M_ALG;
                    gain_next[i*2 +: 2] = G_ALG3;
                end else if (i[2:0] == gs_eff) begin
                    mode_next[i*3 +: 3] = M_GS;
                    gain_next[i*2 +: 2] = rate64 ? G_SQ : G_VQ;
                end else begin
                    mode_next[i*3 +: 3] = M_ADA;
                    gain_next[i*2 +: 2] = rate64 ? G_SQ : G_VQ;
                    pitch_next[i*3 +: 3] = 3'h6;
                end
            end
        end
        if (!rate16 && cfg12 < 3'h4) begin
            case (cfg12)
                // Two impulses in subframe one
                3'h0: begin
                    pitch_next = {3'h0, {1'b1, dbits}, {1'b1, dbits},
                        {1'b1, dbits}, 3'h6};
                end
                // Second impulse in subframe two
                3'h1: begin
                    pitch_next = {3'h0, 3'h6, 3'h6, 3'h7, 3'h0};
                end
                // Subframe three impulse; subframe two loses its first stage
                3'h2: begin
                    mode_next[5:3] = M_ALG;
                    gain_next[3:2] = G_ALG3;
                    pitch_next = {3'h0, {1'b1, dbits}, 3'h7, 3'h0, 3'h0};
                end
                // Impulse in subframe four or in the next frame
                default: begin
                    mode_next[8:3] = {M_ALG, M_ALG};
                    gain_next[5:2] = {G_ALG3, G_ALG3};
                    pitch_next = {3'h0, 3'h7, 3'h0, 3'h0, 3'h0};
                end
            endcase
        end
    end

    // Pitch range for the first coded absolute pitch
    // Eight bits suffice for the lengths used here; a length above 85
    // would wrap the 3N terms, a known limit of this datapath
    reg [7:0] pmin_next;
    reg [7:0] pmax_next;
    always @* begin
        pmin_next = 8'h00;
        pmax_next = 8'h00;
        case (cfg12)
            // Strictly above 34 and below the subframe length
            3'h0: begin pmin_next = `TFBA_PITCH_MIN1 + 8'h01; pmax_next = sub_len - 8'h01; end
            // Lower end shrinks when the impulse sits late
            3'h1: begin
                pmin_next = (sub_len - imp_pos < `TFBA_PITCH_MIN1) ?
                    sub_len - imp_pos : `TFBA_PITCH_MIN1;
                pmax_next = {sub_len[6:0], 1'b0} - 8'h01 - imp_pos;
            end
            // One subframe wide, starting past the second subframe
            3'h2: begin
                pmin_next = {sub_len[6:0], 1'b0} - 8'h01 - imp_pos;
                pmax_next = sub_len + {sub_len[6:0], 1'b0} - 8'h01 - imp_pos;
            end
            // Open upper end, bounded only by the pitch maximum
            default: begin
                pmin_next = sub_len + {sub_len[6:0], 1'b0} - imp_pos;
                pmax_next = `TFBA_PITCH_MAX4;
            end
        endcase
    end

    // Threshold for the index search, midpoint times prediction
    // Midpoint is halved before the product, so one LSB of the table
    // may be lost; the search only needs the ordering
    wire [16:0] mid_sum = {1'b0, table_reg[idx_reg]} +
        {1'b0, table_reg[(idx_reg == 3'h7) ? 3'h7 : idx_reg + 3'h1]};
    wire [47:0] thr_full = pred_reg * {15'h0, mid_sum[16:1]};
    wire [31:0] thr = thr_full[47:16];

    // Quantized gain, entry times prediction, back to 16.16
    wire [47:0] gq_full = pred_reg * {16'h0, table_reg[idx_reg]};

    // Frame sequencer, repeated-subtraction divider, then index search
    // Start is honoured only from idle; the divide takes one cycle per
    // unit of quotient, so large gains cost time, not area
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            // Outputs clear to zero so the packer sees an empty frame
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            idx_reg <= 3'h0;
            gopt_reg <= 32'h0;
            div_cnt_reg <= 32'h0;
            rem_reg <= 32'h0;
            frame_done_reg <= 1'b0;
            prefix_code_reg <= 4'h0;
            prefix_len_reg <= 3'h0;
            sub_mode_reg <= 15'h0;
            pitch_bits_reg <= 15'h0;
            gain_bits_reg <= 10'h0;
            gain_index_reg <= 3'h0;
            gain_quant_reg <= 32'h0;
            pmin_reg <= 8'h0;
            pmax_reg <= 8'h0;
            pitch_cfg_reg <= 3'h0;
        end else begin
            frame_done_reg <= 1'b0;
            case (state_reg)
                // Frame inputs were written before start
                ST_IDLE: begin
                    if (avs_write && !avs_waitrequest && avs_address == `TFBA_ADDR_CTRL
                        && avs_writedata[`TFBA_CTRL_START]) begin
                        state_reg <= ST_CALC;
                        busy_reg <= 1'b1;
                        rem_reg <= corr_reg;
                        gopt_reg <= 32'h0;
                        div_cnt_reg <= 32'h0;
                    end
                end
                ST_CALC: begin
                    // Quotient by repeated subtraction; 16 fractional bits dropped
                    // Capped at 16 integer bits; larger gains saturate
                    if (rem_reg >= energy_reg + {16'h0, `TFBA_GAIN_EPS} &&
                        div_cnt_reg < 32'h0000ffff) begin
                        rem_reg <= rem_reg - energy_reg - {16'h0, `TFBA_GAIN_EPS};
                        gopt_reg <= gopt_reg + 32'h0001_0000;
                        div_cnt_reg <= div_cnt_reg + 32'h1;
                    end else begin
                        // Start at the highest index that has an upper neighbour
                        state_reg <= ST_SRCH;
                        idx_reg <= 3'h6;
                    end
                end
                ST_SRCH: begin
                    // Walking down, the first hit is the largest qualifying index;
                    // with no hit at all the bottom entry is kept
                    if (idx_reg != 3'h0 && !(gopt_reg < thr)) begin
                        idx_reg <= idx_reg - 3'h1;
                    end else begin
                        // Publish all frame fields together with the done pulse
                        gain_index_reg <= idx_reg;
                        gain_quant_reg <= gq_full[47:16];
                        prefix_code_reg <= code_next;
                        prefix_len_reg <= clen_next;
                        sub_mode_reg <= mode_next;
                        pitch_bits_reg <= pitch_next;
                        gain_bits_reg <= gain_next;
                        pmin_reg <= pmin_next;
                        pmax_reg <= pmax_next;
                        pitch_cfg_reg <= cfg12;
                        frame_done_reg <= 1'b1;
                        busy_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Register writes; waitrequest drops one cycle after request
    // Every access takes two cycles: the first edge sees the request
    // with waitrequest high and prepares read data, the second edge
    // completes it with waitrequest low; writes are ignored while busy
    // so a frame in flight always sees stable inputs
    integer k;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            // Table cleared; software must load it before the first frame
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            ctrl_reg <= 3'h0;
            frame_reg <= 24'h0;
            corr_reg <= 32'h0;
            energy_reg <= 32'h0;
            pred_reg <= 32'h0;
            for (k = 0; k < 8; k = k + 1) begin
                table_reg[k] <= 16'h0;
            end
        end else begin
            // Low for exactly one cycle, then back to idle high
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
            end else begin
                avs_waitrequest <= 1'b1;
            end
            // Write lands at the completing edge; start bit never stored
            if (avs_write && !avs_waitrequest && !busy_reg) begin
                case (avs_address)
                    `TFBA_ADDR_CTRL: ctrl_reg <= {avs_writedata[2:1], 1'b0};
                    `TFBA_ADDR_FRAME: frame_reg <= avs_writedata[23:0];
                    `TFBA_ADDR_GAIN: corr_reg <= avs_writedata;
                    `TFBA_ADDR_STATUS: energy_reg <= avs_writedata;
                    `TFBA_ADDR_CFG: pred_reg <= avs_writedata;
                    // Table entries at 8..15; other offsets drop the write
                    default: begin
                        if (avs_address[3]) begin
                            table_reg[avs_address[2:0]] <= avs_writedata[15:0];
                        end
                    end
                endcase
            end
            // Read data prepared one edge early so it stands when sampled
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    `TFBA_ADDR_CTRL: avs_readdata <= {28'h0, busy_reg, ctrl_reg};
                    `TFBA_ADDR_FRAME: avs_readdata <= {8'h0, frame_reg};
                    `TFBA_ADDR_GAIN: avs_readdata <= corr_reg;
                    `TFBA_ADDR_STATUS: avs_readdata <= energy_reg;
                    `TFBA_ADDR_CFG: avs_readdata <= pred_reg;
                    `TFBA_ADDR_PITCH: avs_readdata <= {13'h0, pitch_cfg_reg, pmax_reg, pmin_reg};
                    `TFBA_ADDR_GAINQ: avs_readdata <= {29'h0, gain_index_reg};
                    // Unmapped offsets read zero
                    default: begin
                        avs_readdata <= avs_address[3] ?
                            {16'h0, table_reg[avs_address[2:0]]} : 32'h0;
                    end
                endcase
            end
        end
    end
endmodule // tfba_allocator

// ---- hdl/tfba_regs.vh ----
`ifndef TFBA_REGS_VH
`define TFBA_REGS_VH
// Register word offsets
`define TFBA_ADDR_CTRL 4'h0
`define TFBA_ADDR_FRAME 4'h1
`define TFBA_ADDR_GAIN 4'h2
`define TFBA_ADDR_STATUS 4'h3
`define TFBA_ADDR_CFG 4'h4
`define TFBA_ADDR_PITCH 4'h5
`define TFBA_ADDR_GAINQ 4'h6
`define TFBA_ADDR_TABLE 4'h8
// CTRL fields
`define TFBA_CTRL_START 0
`define TFBA_CTRL_RATE16 1
`define TFBA_CTRL_RATE64 2
// FRAME fields: subframe length, impulse position, glottal subframe
`define TFBA_FR_LEN_LSB 0
`define TFBA_FR_POS_LSB 8
`define TFBA_FR_GS_LSB 16
// Limits
`define TFBA_PITCH_MIN1 8'h22
`define TFBA_PITCH_MAX4 8'he7
`define TFBA_GAIN_EPS 16'h0001
`define TFBA_NSUB16 3'h5
`define TFBA_NSUB12 3'h4
`endif

// ---- verification/tfba_allocator_sva.sv ----
`timescale 1ns/1ps
module tfba_allocator_sva (
    input wire clock,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire frame_done_reg,
    input wire [3:0] prefix_code_reg,
    input wire [2:0] prefix_len_reg,
    input wire [14:0] sub_mode_reg,
    input wire [14:0] pitch_bits_reg,
    input wire [9:0] gain_bits_reg,
    input wire [2:0] gain_index_reg,
    input wire [31:0] gain_quant_reg
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    integer i;
    reg [2:0] m;
    reg [2:0] gs_cnt;
    reg early_bad;
    reg gain_bad;
    reg pitch_bad;
    // Per-subframe summary; a mode of 2 seen before any glottal slot is out of order
    always @* begin
        gs_cnt = 3'h0;
        early_bad = 1'b0;
        gain_bad = 1'b0;
        pitch_bad = 1'b0;
        for (i = 0; i < 5; i = i + 1) begin
            m = sub_mode_reg[3*i+:3];
            if (m == 3'h2 && gs_cnt == 3'h0) early_bad = 1'b1;
            if (m == 3'h1) gs_cnt = gs_cnt + 3'h1;
            if ((m == 3'h0) == gain_bits_reg[2*i+1]) gain_bad = 1'b1;
            if (pitch_bits_reg[3*i+:3] != 3'h0 && pitch_bits_reg[3*i+:3] < 3'h5) pitch_bad = 1'b1;
        end
    end
    wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one cycle");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    done_pulse_a: assert property (frame_done_reg |=> !frame_done_reg)
        else $error("frame done longer than one cycle");
    one_glottal_a: assert property (frame_done_reg |-> gs_cnt == 3'h1)
        else $error("glottal subframe count not one");
    alg_before_a: assert property (frame_done_reg |-> !early_bad)
        else $error("adaptive subframe before glottal subframe");
    gain_kind_a: assert property (frame_done_reg |-> !gain_bad)
        else $error("gain field kind disagrees with subframe mode");
    pitch_width_a: assert property (frame_done_reg |-> !pitch_bad)
        else $error("pitch field width not 0, 5, 6 or 7");
    prefix_fit_a: assert property (frame_done_reg |-> prefix_len_reg inside {[3'h1:3'h4]} &&
        (prefix_code_reg >> prefix_len_reg) == 4'h0)
        else $error("prefix code wider than its length");
    hold_out_a: assert property (!frame_done_reg |-> $stable(sub_mode_reg) &&
        $stable(gain_index_reg) && $stable(gain_quant_reg))
        else $error("frame outputs changed without frame done");
    cover property (frame_done_reg);
    cover property (avs_read && !avs_waitrequest);
    cover property (avs_write && !avs_waitrequest);
endmodule // tfba_allocator_sva

bind tfba_allocator tfba_allocator_sva u_sva (.clock(clock), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame_done_reg(frame_done_reg),
    .prefix_code_reg(prefix_code_reg), .prefix_len_reg(prefix_len_reg),
    .sub_mode_reg(sub_mode_reg), .pitch_bits_reg(pitch_bits_reg),
    .gain_bits_reg(gain_bits_reg), .gain_index_reg(gain_index_reg),
    .gain_quant_reg(gain_quant_reg));

// ---- verification/tfba_packer_model.sv ----
`timescale 1ns/1ps
module tfba_packer_model (
    input wire clock,
    input wire rst,
    input wire frame_done_reg,
    output reg [15:0] frames_taken
);
    // Packer takes the fields on the done pulse; they hold until the next one
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            frames_taken <= 16'h0;
        end else if (frame_done_reg) begin
            frames_taken <= frames_taken + 16'h1;
        end
    end
endmodule // tfba_packer_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`include "tfba_regs.vh"
module tb;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg [3:0] avs_address = 4'h0;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    wire [31:0] avs_readdata, gain_quant_reg;
    wire avs_waitrequest, frame_done_reg;
    wire [3:0] prefix_code_reg;
    wire [2:0] prefix_len_reg, gain_index_reg;
    wire [14:0] sub_mode_reg, pitch_bits_reg;
    wire [9:0] gain_bits_reg;
    wire [15:0] frames_taken;
    integer fails = 0;
    integer n_compared = 0;
    integer g, r, i, ex;
    reg [31:0] rd;
    reg [14:0] em, ep;
    reg [9:0] eg;
    reg [2:0] d, gs;
    always #5 clock = ~clock;
    tfba_allocator DUT (.clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .frame_done_reg(frame_done_reg), .prefix_code_reg(prefix_code_reg),
        .prefix_len_reg(prefix_len_reg), .sub_mode_reg(sub_mode_reg),
        .pitch_bits_reg(pitch_bits_reg), .gain_bits_reg(gain_bits_reg),
        .gain_index_reg(gain_index_reg), .gain_quant_reg(gain_quant_reg));
    tfba_packer_model PKR (.clock(clock), .rst(rst), .frame_done_reg(frame_done_reg),
        .frames_taken(frames_taken));
    // Decreasing table so the threshold search has a nontrivial answer
    function [31:0] tab(input integer k);
        tab = 32'hf000 - 32'h2000 * k;
    endfunction
    task end_sim;
        begin
            $display("compared %0d mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] s);
        begin
            n_compared = n_compared + 1;
            if (s !== e) begin
                fails = fails + 1;
                $display("[ERR] %s exp %h got %h", nm, e, s);
            end
        end
    endtask
    // Entered at a rising edge; waitrequest and read data taken at one edge
    task acc(input w, input [3:0] a, input [31:0] dat);
        integer k;
        begin
            avs_address <= a;
            avs_writedata <= dat;
            avs_write <= w;
            avs_read <= !w;
            k = 0;
            @(posedge clock);
            while (avs_waitrequest !== 1'b0) begin
                k = k + 1;
                if (k > 50) begin
                    fails = fails + 1;
                    end_sim;
                end
                @(posedge clock);
            end
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge clock);
        end
    endtask
    // Frame fields go in before start, so the datapath side is always first
    task run(input [31:0] ctl, input [31:0] fr);
        integer k, n;
        begin
            n = frames_taken;
            acc(1'b1, `TFBA_ADDR_FRAME, fr);
            acc(1'b1, `TFBA_ADDR_CTRL, ctl);
            k = 0;
            while (frames_taken == n) begin
                @(posedge clock);
                k = k + 1;
                if (k > 3000) begin
                    fails = fails + 1;
                    end_sim;
                end
            end
        end
    endtask
    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        chk("wait_rst", 32'h1, avs_waitrequest);
        chk("mode_rst", 32'h0, sub_mode_reg);
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        acc(1'b1, 4'h7, 32'hffffffff);
        acc(1'b0, 4'h7, 32'h0);
        chk("unmapped", 32'h0, rd);
        acc(1'b0, `TFBA_ADDR_CTRL, 32'h0);
        chk("ctrl_rst", 32'h0, rd);
        // Gain datapath inputs: 2.0 over energy, prediction 4.0
        acc(1'b1, `TFBA_ADDR_GAIN, 32'h20000);
        acc(1'b1, `TFBA_ADDR_STATUS, 32'hffff);
        acc(1'b1, `TFBA_ADDR_CFG, 32'h40000);
        for (i = 0; i < 8; i = i + 1) acc(1'b1, `TFBA_ADDR_TABLE + i, tab(i));
        ex = 0;
        for (i = 0; i < 7; i = i + 1) begin
            if ((64'h20000 << 17) < (tab(i) + tab(i + 1)) * 64'h40000) ex = i;
        end
        // Five placements at the wide rate, both bit-rates
        for (r = 0; r < 2; r = r + 1) begin
            for (g = 0; g < 5; g = g + 1) begin
                run({29'h0, r[0], 2'h3}, {13'h0, g[2:0], 16'h1040});
                for (i = 0; i < 5; i = i + 1) begin
                    em[3*i+:3] = (i < g) ? 3'h0 : (i == g) ? 3'h1 : 3'h2;
                    eg[2*i+:2] = (i < g) ? 2'h1 : (r ? 2'h3 : 2'h2);
                end
                chk("code16", (g < 3) ? g : g + 3, prefix_code_reg);
                chk("len16", (g < 3) ? 2 : 3, prefix_len_reg);
                chk("mode16", em, sub_mode_reg);
                chk("gain16", eg, gain_bits_reg);
            end
        end
        // Seven configurations at the narrow rate
        for (r = 0; r < 2; r = r + 1) begin
            for (g = 0; g < 7; g = g + 1) begin
                run({29'h0, r[0], 2'h1}, {10'h0, g[2:0], 19'h1040});
                gs = (g < 4) ? 3'h0 : g - 3;
                d = r ? 3'h6 : 3'h5;
                for (i = 0; i < 4; i = i + 1) begin
                    em[3*i+:3] = (i < gs) ? 3'h0 : (i == gs) ? 3'h1 : 3'h2;
                    if ((g == 2 && i == 1) || (g == 3 && (i == 1 || i == 2))) em[3*i+:3] = 3'h0;
                    eg[2*i+:2] = (em[3*i+:3] == 3'h0) ? 2'h1 : (r ? 2'h3 : 2'h2);
                end
                chk("code12", (28'h0113451 >> (4 * g)) & 4'hf, prefix_code_reg);
                chk("len12", (28'h4433441 >> (4 * g)) & 4'hf, prefix_len_reg);
                chk("mode12", em[11:0], sub_mode_reg[11:0]);
                chk("gain12", eg[7:0], gain_bits_reg[7:0]);
                ep = 15'h0;
                if (g == 0) ep[11:0] = {d, d, d, 3'h6};
                if (g == 1) ep[11:0] = {3'h6, 3'h6, 3'h7, 3'h0};
                if (g == 2) ep[11:0] = {d, 3'h7, 6'h0};
                if (g == 3) ep[11:0] = {3'h7, 9'h0};
                if (g < 4) chk("pitch12", ep[11:0], pitch_bits_reg[11:0]);
            end
        end
        chk("gain_idx", ex, gain_index_reg);
        chk("gain_q", (tab(ex) * 64'h40000) >> 16, gain_quant_reg);
        acc(1'b0, `TFBA_ADDR_GAINQ, 32'h0);
        chk("idx_reg", ex, rd);
        // Last frame was configuration seven: range 3N-k' up to 231
        acc(1'b0, `TFBA_ADDR_PITCH, 32'h0);
        chk("pitch_rng", 32'h0006e7b0, rd);
        end_sim;
    end
endmodule // tb
